// >>> hw/exc_ctrl_defines.vh
// Purpose: Constants of the exception and interrupt control block
// Assumes: APB byte addresses, 32-bit data, 50 MHz pclk
// Notes:   Contract
// Contract
// RULE_01: On reset release module stops load 3F, FF, FF; transfer engine stays on.
// RULE_02: Peripheral register access is refused while that peripheral is stopped.
// RULE_03: Tracing works only in control mode 2, never in mode 0.
// RULE_04: Trace bit set raises trace exception after each instruction, ignoring masks.
// RULE_05: Trace entry sets I, clears T, keeps user flag and priority mask.
// RULE_06: Return restores stacked T; the return instruction itself is not traced.
// RULE_07: Interrupts stay accepted inside the trace handler.
// RULE_08: Interrupt entry pushes PC, CONDITION_CODE_REG, EXTENDED_CONTROL_REG, updates mask, clears T, fetches vector.
// RULE_08 (code): mask update and T clear happen in mode 2 only.
// RULE_09: Trap instruction starts trap handling anytime, same order as interrupts.
// RULE_10: Trap carries vector number 0 to 3 selecting its table entry.
// RULE_11: Trap sets I in both modes; clears T in mode 2 only.
// RULE_12: Word stack addresses force bit 0 low; software keeps SP even.
// RULE_13: Two control modes chosen by two mode select bits.
// RULE_14: Maskable sources have eight levels; nonmaskable is level 8, always taken.
// RULE_15: Every source has its own vector.
// RULE_16: Nonmaskable input senses rising or falling edge by configuration.
// RULE_17: Six external requests sense falling, rising, both edges or low level.
// RULE_18: An accepted request may start the transfer engine instead of the CPU.
// RULE_19: After reset mode 0, all requests blocked until the first instruction.
// RULE_20: Priority fields are 3 bits, 000 lowest through 111 highest.
// RULE_21: Highest level above mask wins; ties go to the lowest source index.
`ifndef EXC_CTRL_DEFINES_VH
`define EXC_CTRL_DEFINES_VH
`define OFS_SYSCTL    8'h00
`define OFS_SENSE     8'h04
`define OFS_ENABLE    8'h08
`define OFS_STATUS    8'h0C
`define OFS_PRIO      8'h10
`define OFS_XFER_SEL  8'h14
`define OFS_MSTOP_A   8'h18
`define OFS_MSTOP_B   8'h1C
`define OFS_MSTOP_C   8'h20
`define OFS_CORE_STAT 8'h24
`define MODE_LO_BIT   0
`define MODE_HI_BIT   1
`define NMI_EDGE_BIT  3
`define CS_I_BIT      7
`define CS_UI_BIT     6
`define CS_T_BIT      3
`define CS_MASK_LSB   0
`define MSTOP_A_RST   8'h3F
`define MSTOP_B_RST   8'hFF
`define MSTOP_C_RST   8'hFF
`define XFER_STOP_BIT 6
`define MODE_2        2'h2
`define NMI_LEVEL     4'h8
`define VEC_TRACE     7'h05
`define VEC_NMI       7'h07
`define VEC_TRAP0     7'h08
`define VEC_EXT0      7'h10
`define SENSE_LOW     2'h0
`define SENSE_FALL    2'h1
`define SENSE_RISE    2'h2
`define SENSE_BOTH    2'h3
`endif

// >>> hw/exception_interrupt_control.v
// Purpose: Exception sequencer and external interrupt front end
// Assumes: Inputs synchronous to pclk; core holds SP and pushes words
// Notes:   APB slave with one wait state; constants in exc_ctrl_defines.vh
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`include "exc_ctrl_defines.vh"
module exception_interrupt_control (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_q,
  output reg         pready_q,
  output reg         pslverr_q,
  input  wire        nmi_pin,
  input  wire [5:0]  ext_request,
  input  wire        instr_done,
  input  wire        instr_is_rte,
  input  wire        rte_load,
  input  wire        rte_ccr_i,
  input  wire        rte_ui,
  input  wire        rte_t,
  input  wire [2:0]  rte_mask,
  input  wire        trap_exec,
  input  wire [1:0]  trap_num,
  input  wire [31:0] stack_ptr,
  input  wire        fetch_ack,
  input  wire        per_req,
  input  wire [4:0]  per_idx,
  output reg         stack_push_q,
  output reg  [1:0]  stack_sel_q,
  output reg  [31:0] stack_addr_q,
  output reg         fetch_req_q,
  output reg  [6:0]  exc_vec_q,
  output reg         ccr_i_q,
  output reg         ccr_ui_q,
  output reg         exr_t_q,
  output reg  [2:0]  exr_mask_q,
  output reg         xfer_req_q,
  output reg  [2:0]  xfer_src_q,
  output reg         per_grant_q,
  output reg         per_deny_q
);
  localparam S_IDLE = 3'h0;
  localparam S_PC   = 3'h1;
  localparam S_CCR  = 3'h2;
  localparam S_EXR  = 3'h3;
  localparam S_UPD  = 3'h4;
  localparam S_VEC  = 3'h5;
  localparam K_INT  = 2'h0;
  localparam K_TRC  = 2'h1;
  localparam K_TRP  = 2'h2;

  reg  [7:0]  sysctl_q;
  reg  [11:0] sense_q;
  reg  [5:0]  enable_q;
  reg  [5:0]  flag_q;
  reg  [5:0]  flag_d;
  reg  [23:0] prio_q;
  reg  [5:0]  xsel_q;
  reg  [7:0]  mstop_a_q;
  reg  [7:0]  mstop_b_q;
  reg  [7:0]  mstop_c_q;
  reg  [5:0]  ext_prev_q;
  reg         nmi_prev_q;
  reg         nmi_flag_q;
  reg         run_q;
  reg         trace_pend_q;
  reg         trap_pend_q;
  reg  [1:0]  trap_num_q;
  reg  [2:0]  state_q;
  reg  [1:0]  kind_q;
  reg  [3:0]  lvl_q;
  reg  [5:0]  ext_hit;
  wire [1:0]  mode = {sysctl_q[`MODE_HI_BIT], sysctl_q[`MODE_LO_BIT]}; // [RULE_13]
  wire        mode2 = (mode == `MODE_2);
  wire        acc = psel & penable & pready_q;
  wire        wr = acc & pwrite;
  wire        clr_st = wr & (paddr == `OFS_STATUS);
  wire        nmi_edge = sysctl_q[`NMI_EDGE_BIT] ? (nmi_pin & ~nmi_prev_q)
                                                  : (~nmi_pin & nmi_prev_q); // [RULE_16]

  // Per-input sensing, one detector per request line
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_sense
      always @* begin
        case (sense_q[2*g+1:2*g]) // [RULE_17]
          `SENSE_LOW:  ext_hit[g] = ~ext_request[g];
          `SENSE_FALL: ext_hit[g] = ~ext_request[g] & ext_prev_q[g];
          `SENSE_RISE: ext_hit[g] = ext_request[g] & ~ext_prev_q[g];
          default:     ext_hit[g] = ext_request[g] ^ ext_prev_q[g];
        endcase
      end
    end
  endgenerate

  // Arbitration among pending enabled requests
  reg  [2:0] best_src;
  reg  [2:0] best_lvl;
  reg        best_ok;
  integer    i;
  always @* begin
    best_src = 3'h0;
    best_lvl = 3'h0;
    best_ok  = 1'b0;
    for (i = 0; i < 6; i = i + 1) begin
      if (flag_q[i] && enable_q[i] &&
          (!best_ok || prio_q[4*i+:3] > best_lvl)) begin // [RULE_20] [RULE_21]
        best_ok  = 1'b1;
        best_src = i[2:0];
        best_lvl = prio_q[4*i+:3];
      end
    end
  end

  // Mode 0 gates by I alone; mode 2 by level above mask, ignoring I
  wire ext_take = best_ok & (mode2 ? ({1'b0, best_lvl} > {1'b0, exr_mask_q})
                                   : ~ccr_i_q); // [RULE_07] [RULE_14]
  wire to_xfer  = xsel_q[best_src] & ~mstop_a_q[`XFER_STOP_BIT];
  wire idle     = (state_q == S_IDLE);
  wire go_trace = idle & trace_pend_q;
  wire go_nmi   = idle & run_q & ~trace_pend_q & nmi_flag_q; // [RULE_14]
  wire go_ext   = idle & run_q & ~trace_pend_q & ~nmi_flag_q & ext_take; // [RULE_19]
  wire go_trap  = idle & trap_pend_q & ~trace_pend_q & ~nmi_flag_q & ~(run_q & ext_take);
  wire ext_cpu  = go_ext & ~to_xfer;

  always @* begin
    flag_d = flag_q;
    if (clr_st)
      flag_d = flag_q & ~pwdata[5:0];
    if (go_ext && sense_q[2*best_src+:2] != `SENSE_LOW)
      flag_d[best_src] = 1'b0;
    flag_d = flag_d | ext_hit; // Set wins over any clear
  end

  // Register file and request capture
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysctl_q     <= 8'h00; // [RULE_19]
      sense_q      <= 12'h000;
      enable_q     <= 6'h00;
      flag_q       <= 6'h00;
      prio_q       <= 24'h777777;
      xsel_q       <= 6'h00;
      mstop_a_q    <= `MSTOP_A_RST; // [RULE_01]
      mstop_b_q    <= `MSTOP_B_RST; // [RULE_01]
      mstop_c_q    <= `MSTOP_C_RST; // [RULE_01]
      ext_prev_q   <= 6'h3F;
      nmi_prev_q   <= 1'b1; // Idle level, so no false edge after reset
      nmi_flag_q   <= 1'b0;
      run_q        <= 1'b0;
      trace_pend_q <= 1'b0;
      trap_pend_q  <= 1'b0;
      trap_num_q   <= 2'h0;
    end else begin
      ext_prev_q <= ext_request;
      nmi_prev_q <= nmi_pin;
      flag_q     <= flag_d;
      if (instr_done)
        run_q <= 1'b1; // [RULE_19]
      if (nmi_edge)
        nmi_flag_q <= 1'b1;
      else if (go_nmi)
        nmi_flag_q <= 1'b0;
      if (instr_done && exr_t_q && mode2 && !instr_is_rte)
        trace_pend_q <= 1'b1; // [RULE_03] [RULE_04] [RULE_06]
      else if (go_trace)
        trace_pend_q <= 1'b0;
      if (trap_exec) begin
        trap_pend_q <= 1'b1; // [RULE_09]
        trap_num_q  <= trap_num;
      end else if (go_trap) begin
        trap_pend_q <= 1'b0;
      end
      if (wr) begin
        case (paddr)
          `OFS_SYSCTL:   sysctl_q  <= pwdata[7:0] & 8'h0B;
          `OFS_SENSE:    sense_q   <= pwdata[11:0];
          `OFS_ENABLE:   enable_q  <= pwdata[5:0];
          `OFS_PRIO:     prio_q    <= pwdata[23:0] & 24'h777777;
          `OFS_XFER_SEL: xsel_q    <= pwdata[5:0];
          `OFS_MSTOP_A:  mstop_a_q <= pwdata[7:0];
          `OFS_MSTOP_B:  mstop_b_q <= pwdata[7:0];
          `OFS_MSTOP_C:  mstop_c_q <= pwdata[7:0];
          default:       ;
        endcase
      end
    end
  end

  // APB answer one cycle into the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= 1'b0;
      if (psel && penable && !pready_q) begin
        prdata_q <= 32'h00000000;
        case (paddr)
          `OFS_SYSCTL:    prdata_q[7:0]  <= sysctl_q;
          `OFS_SENSE:     prdata_q[11:0] <= sense_q;
          `OFS_ENABLE:    prdata_q[5:0]  <= enable_q;
          `OFS_STATUS:    prdata_q[5:0]  <= flag_q;
          `OFS_PRIO:      prdata_q[23:0] <= prio_q;
          `OFS_XFER_SEL:  prdata_q[5:0]  <= xsel_q;
          `OFS_MSTOP_A:   prdata_q[7:0]  <= mstop_a_q;
          `OFS_MSTOP_B:   prdata_q[7:0]  <= mstop_b_q;
          `OFS_MSTOP_C:   prdata_q[7:0]  <= mstop_c_q;
          `OFS_CORE_STAT: prdata_q[7:0]  <= {ccr_i_q, ccr_ui_q, 2'h0, exr_t_q, exr_mask_q};
          default:        pslverr_q      <= 1'b1;
        endcase
      end
    end
  end

  // Peripheral register gate; index 0-7 A, 8-15 B, 16-23 C
  wire [23:0] mstop_all = {mstop_c_q, mstop_b_q, mstop_a_q};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_grant_q <= 1'b0;
      per_deny_q  <= 1'b0;
    end else begin
      per_grant_q <= per_req & (per_idx < 5'd24) & ~mstop_all[per_idx]; // [RULE_02]
      per_deny_q  <= per_req & ((per_idx >= 5'd24) | mstop_all[per_idx]); // [RULE_02]
    end
  end

  // Exception entry sequencer and core status bits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q      <= S_IDLE;
      kind_q       <= K_INT;
      lvl_q        <= 4'h0;
      stack_push_q <= 1'b0;
      stack_sel_q  <= 2'h0;
      stack_addr_q <= 32'h00000000;
      fetch_req_q  <= 1'b0;
      exc_vec_q    <= 7'h00;
      ccr_i_q      <= 1'b1;
      ccr_ui_q     <= 1'b0;
      exr_t_q      <= 1'b0;
      exr_mask_q   <= 3'h7;
      xfer_req_q   <= 1'b0;
      xfer_src_q   <= 3'h0;
    end else begin
      stack_push_q <= 1'b0;
      xfer_req_q   <= 1'b0;
      if (rte_load) begin
        ccr_i_q    <= rte_ccr_i;
        ccr_ui_q   <= rte_ui;
        exr_t_q    <= rte_t; // [RULE_06]
        exr_mask_q <= rte_mask;
      end else if (wr && paddr == `OFS_CORE_STAT) begin
        ccr_i_q    <= pwdata[`CS_I_BIT];
        ccr_ui_q   <= pwdata[`CS_UI_BIT];
        exr_t_q    <= pwdata[`CS_T_BIT];
        exr_mask_q <= pwdata[`CS_MASK_LSB+:3];
      end
      if (go_ext && to_xfer) begin
        xfer_req_q <= 1'b1; // [RULE_18]
        xfer_src_q <= best_src;
      end
      case (state_q)
        S_IDLE: begin
          if (go_trace) begin
            kind_q    <= K_TRC;
            exc_vec_q <= `VEC_TRACE; // [RULE_15]
            state_q   <= S_PC;
          end else if (go_nmi) begin
            kind_q    <= K_INT;
            lvl_q     <= `NMI_LEVEL;
            exc_vec_q <= `VEC_NMI; // [RULE_15]
            state_q   <= S_PC;
          end else if (ext_cpu) begin
            kind_q    <= K_INT;
            lvl_q     <= {1'b0, best_lvl};
            exc_vec_q <= `VEC_EXT0 + {4'h0, best_src}; // [RULE_15]
            state_q   <= S_PC;
          end else if (go_trap) begin
            kind_q    <= K_TRP;
            exc_vec_q <= `VEC_TRAP0 + {5'h00, trap_num_q}; // [RULE_10]
            state_q   <= S_PC;
          end
        end
        S_PC, S_CCR, S_EXR: begin
          stack_push_q <= 1'b1; // [RULE_08]
          stack_sel_q  <= state_q[1:0] - 2'h1;
          stack_addr_q <= {stack_ptr[31:1], 1'b0}; // [RULE_12]
          state_q      <= state_q + 3'h1;
        end
        S_UPD: begin
          ccr_i_q <= 1'b1; // [RULE_05] [RULE_11]
          if (mode2)
            exr_t_q <= 1'b0; // [RULE_05] [RULE_08] [RULE_11]
          if (kind_q == K_INT && mode2)
            exr_mask_q <= (lvl_q > 4'h7) ? 3'h7 : lvl_q[2:0]; // [RULE_08]
          fetch_req_q <= 1'b1;
          state_q     <= S_VEC;
        end
        S_VEC: begin
          if (fetch_ack) begin
            fetch_req_q <= 1'b0; // [RULE_08]
            state_q     <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule

// >>> verification/exc_ctrl_chk.sv
// Purpose: Port-level assertions for the exception sequencer
// Assumes: Single pclk domain, presetn async active low
// Notes:   Bound into every instance of the design
module exc_ctrl_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready_q,
  input wire logic        per_req,
  input wire logic        per_grant_q,
  input wire logic        per_deny_q,
  input wire logic        stack_push_q,
  input wire logic [1:0]  stack_sel_q,
  input wire logic [31:0] stack_addr_q,
  input wire logic        fetch_req_q,
  input wire logic        fetch_ack,
  input wire logic [6:0]  exc_vec_q,
  input wire logic        ccr_i_q,
  input wire logic        ccr_ui_q,
  input wire logic        exr_t_q,
  input wire logic [2:0]  exr_mask_q,
  input wire logic        xfer_req_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_apb_wait: assert property ($rose(penable) && psel |=> pready_q ##1 !pready_q)
    else $error("access not answered after one wait state");
  chk_periph_gate: assert property (per_req |=> per_grant_q != per_deny_q)
    else $error("peripheral access neither granted nor denied");
  chk_push_order: assert property ($rose(stack_push_q) |-> stack_sel_q == 2'h0 ##1
    stack_push_q && stack_sel_q == 2'h1 ##1 stack_push_q && stack_sel_q == 2'h2 ##1 !stack_push_q)
    else $error("stack pushes out of order");
  chk_fetch_after: assert property (stack_push_q && stack_sel_q == 2'h2 |-> ##1 $rose(fetch_req_q))
    else $error("vector fetch not one cycle after last push");
  chk_fetch_hold: assert property (fetch_req_q && !fetch_ack |=> fetch_req_q)
    else $error("fetch request dropped early");
  chk_fetch_end: assert property (fetch_req_q && fetch_ack |=> !fetch_req_q)
    else $error("fetch request held after ack");
  chk_stack_even: assert property (stack_push_q |-> !stack_addr_q[0])
    else $error("odd stack address");
  chk_mask_set: assert property ($rose(fetch_req_q) |-> ccr_i_q)
    else $error("interrupt mask not set on entry");
  chk_trace_state: assert property ($rose(fetch_req_q) && exc_vec_q == 7'h05 |->
    !exr_t_q && ccr_ui_q == $past(ccr_ui_q, 4))
    else $error("trace entry status wrong");
  chk_nmi_mask: assert property ($rose(fetch_req_q) && exc_vec_q == 7'h07 |-> exr_mask_q == 3'h7)
    else $error("nonmaskable entry mask wrong");
  cover property ($rose(fetch_req_q) && exc_vec_q == 7'h05);
  cover property (xfer_req_q);
  cover property (per_deny_q);
endmodule
bind exception_interrupt_control exc_ctrl_chk u_chk (.*);

// >>> verification/exc_peer.sv
// Purpose: Far-side model: request pins and vector fetch responder
// Assumes: Pins idle high; ack latency set by ack_dly
// Notes:   Pins change only after a clock edge
module exc_peer (
  input  wire logic       pclk,
  input  wire logic       fetch_req_q,
  input  wire logic [3:0] ack_dly,
  output logic            fetch_ack,
  output logic            nmi_pin,
  output logic [5:0]      ext_request
);
  logic [3:0] cnt;
  initial begin
    {fetch_ack, nmi_pin, ext_request, cnt} = {1'b0, 1'b1, 6'h3F, 4'h0};
  end
  // Slow or prompt answer, one-cycle ack pulse
  always @(posedge pclk) begin
    if (fetch_req_q && !fetch_ack) begin
      cnt <= cnt + 4'h1;
      fetch_ack <= (cnt >= ack_dly);
    end else begin
      {cnt, fetch_ack} <= 5'h00;
    end
  end
  task automatic drive(input logic n, input logic [5:0] e);
    @(posedge pclk);
    {nmi_pin, ext_request} <= {n, e};
  endtask
endmodule

// >>> verification/exception_interrupt_control_tb_top.sv
// Purpose: Directed scenarios for the exception and interrupt block
// Assumes: 50 MHz pclk, APB master with held requests
// Notes:   Odd stack pointer on purpose; design must force bit 0 low
module exception_interrupt_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
  logic pclk, presetn, psel, penable, pwrite, instr_done, instr_is_rte, rte_load;
  logic rte_ccr_i, rte_ui, rte_t, trap_exec, per_req, nmi_pin, fetch_ack, perr;
  logic pready_q, pslverr_q, stack_push_q, fetch_req_q, ccr_i_q, ccr_ui_q, exr_t_q;
  logic xfer_req_q, per_grant_q, per_deny_q;
  logic [1:0]  trap_num, stack_sel_q;
  logic [2:0]  rte_mask, exr_mask_q, xfer_src_q;
  logic [3:0]  ack_dly;
  logic [4:0]  per_idx;
  logic [5:0]  ext_request;
  logic [6:0]  exc_vec_q;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata_q, stack_ptr, stack_addr_q, rv;
  int          err_total, samples_checked, cyc;
  exception_interrupt_control u_dut (.*);
  exc_peer u_peer (.*);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready_q !== 1'b1 && n < 50);
    if (n >= 50)
      err_total++;
    {rv, perr} = {prdata_q, pslverr_q};
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task automatic step(input logic r);
    {instr_done, instr_is_rte} <= {1'b1, r};
    @(posedge pclk) {instr_done, instr_is_rte} <= 2'b00;
  endtask
  task automatic trap(input logic [1:0] t);
    {trap_exec, trap_num} <= {1'b1, t};
    @(posedge pclk) trap_exec <= 1'b0;
  endtask
  task automatic wait_exc(input logic [6:0] v);
    int n;
    n = 0;
    while (fetch_req_q !== 1'b1 && n < 40) begin @(posedge pclk); n++; end
    `CHK(fetch_req_q, 1'b1)
    `CHK(exc_vec_q, v)
    while (fetch_req_q === 1'b1 && n < 80) begin @(posedge pclk); n++; end
  endtask
  task automatic quiet();
    repeat (8) @(posedge pclk);
  endtask
  task automatic t_reset();
    apb(0, 8'h18, 0); `CHK(rv, 32'h3F)
    apb(0, 8'h1C, 0); `CHK(rv, 32'hFF)
    apb(0, 8'h20, 0); `CHK(rv, 32'hFF)
    apb(0, 8'h24, 0); `CHK(rv, 32'h87)
    apb(1, 8'h40, 32'h5); `CHK(perr, 1'b1)
    {per_req, per_idx} <= 6'h20;
    repeat (2) @(posedge pclk); `CHK(per_deny_q, 1'b1)
    apb(1, 8'h18, 0);
    repeat (2) @(posedge pclk); `CHK(per_grant_q, 1'b1)
    per_req <= 1'b0;
    u_peer.drive(0, 6'h3F); quiet(); `CHK(fetch_req_q, 1'b0)
    u_peer.drive(1, 6'h3F); step(0); repeat (20) @(posedge pclk);
  endtask
  task automatic t_nmi();
    ack_dly <= 4'h3;
    apb(1, 8'h00, 32'h08);
    u_peer.drive(0, 6'h3F); quiet(); `CHK(fetch_req_q, 1'b0)
    u_peer.drive(1, 6'h3F); wait_exc(7'h07); `CHK(exr_mask_q, 3'h7)
    ack_dly <= 4'h0;
  endtask
  task automatic t_irq();
    apb(1, 8'h00, 32'h0A); apb(1, 8'h08, 32'h3F); apb(1, 8'h04, 32'hE4);
    for (int s = 0; s < 4; s++) begin
      apb(1, 8'h24, 0);
      u_peer.drive(1, ~(6'h01 << s));
      if (s == 2) begin quiet(); `CHK(fetch_req_q, 1'b0) end
      else wait_exc(7'(16 + s));
      u_peer.drive(1, 6'h3F);
      if (s == 2) wait_exc(7'h12);
      `CHK(exr_mask_q, 3'h7)
      quiet(); apb(1, 8'h0C, 32'h3F);
    end
  endtask
  task automatic t_prio();
    apb(1, 8'h04, 0); apb(1, 8'h10, 32'h53); apb(1, 8'h24, 32'h04);
    u_peer.drive(1, 6'h3C); wait_exc(7'h11);
    `CHK(exr_mask_q, 3'h5)
    u_peer.drive(1, 6'h3F); quiet(); apb(1, 8'h0C, 32'h3F);
  endtask
  task automatic t_trap();
    apb(1, 8'h00, 32'h08);
    for (int n = 0; n < 4; n++) begin
      apb(1, 8'h24, 32'h08); trap(2'(n)); wait_exc(7'(8 + n));
      `CHK({ccr_i_q, exr_t_q}, 2'b11)
    end
    step(0); quiet(); `CHK(fetch_req_q, 1'b0)
    apb(1, 8'h00, 32'h0A); trap(2'h3); wait_exc(7'h0B);
    `CHK({ccr_i_q, exr_t_q}, 2'b10)
  endtask
  task automatic t_trace();
    apb(1, 8'h10, 32'h777777); apb(1, 8'h24, 32'hCA);
    step(0); wait_exc(7'h05);
    `CHK({ccr_i_q, ccr_ui_q, exr_t_q, exr_mask_q}, 6'b110010)
    u_peer.drive(1, 6'h3B); wait_exc(7'h12);
    u_peer.drive(1, 6'h3F); quiet(); apb(1, 8'h0C, 32'h3F);
    {rte_load, rte_ccr_i, rte_ui, rte_t, rte_mask} <= 7'b1011010;
    step(1); rte_load <= 1'b0;
    quiet(); `CHK({fetch_req_q, exr_t_q}, 2'b01)
    step(0); wait_exc(7'h05);
  endtask
  task automatic t_xfer();
    int n;
    apb(1, 8'h14, 32'h08); apb(1, 8'h24, 0); u_peer.drive(1, 6'h37);
    n = 0;
    while (xfer_req_q !== 1'b1 && n < 30) begin @(posedge pclk); n++; end
    `CHK(xfer_src_q, 3'h3)
    `CHK(fetch_req_q, 1'b0)
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, per_req, per_idx} = '0;
    {instr_done, instr_is_rte, rte_load, rte_ccr_i, rte_ui, rte_t, rte_mask} = '0;
    {trap_exec, trap_num, ack_dly, cyc, err_total, samples_checked} = '0;
    stack_ptr = 32'h0000_1001;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset(); $display("reset test done");
    t_nmi(); $display("nmi test done");
    t_irq(); $display("sense test done");
    t_prio(); $display("priority test done");
    t_trap(); $display("trap test done");
    t_trace(); $display("trace test done");
    t_xfer(); $display("transfer test done");
    finish_test();
  end
endmodule
